// file: hdl/ecrp_regs.sv
// Epoch seconds counter, scratch bytes and unlock key entry register bank.
`default_nettype none
// Overview of operation
// R1 - The epoch count is one 32-bit plain binary value.
// R2 - An all-ones count that advances wraps to zero.
// R3 - The count advances by one on each 1 Hz tick.
// R4 - Ticks are dropped while the host writes an epoch byte.
// R5 - The count reads as four bytes, lowest at 1Bh, highest at 1Eh.
// R6 - All four epoch bytes are readable and writable.
// R7 - Reads always work; writes are blocked while locked. The key bytes 21h to 24h still take writes while locked.
// R8 - Two scratch bytes at 1Fh and 20h simply store data.
// R9 - After the first refresh of about 66 ms the key bytes clear.
// R10 - Protection applies only when the enable byte holds 255.
// R11 - The entered key is compared with the stored 32-bit reference.
// R12 - The host writes the matching key before protected writes.
// R13 - The key byte at 21h holds key bits 7 to 0.
// R14 - Key bytes are write-only and read as zero.
// R15 - Key bytes 22h to 24h hold bits 15-8, 23-16 and 31-24.
// R16 - Without protection, writes need no key.
// R17 - Reset clears the epoch count and scratch bytes.
module ecrp_regs #(
  parameter int REFRESH_CYCLES = ecrp_pkg::REFRESH_CYCLES
) (
  input wire logic clock_in, // 50 MHz clock
  input wire logic rst_n_in, // Asynchronous power-on reset
  input wire logic tick_in, // One-cycle tuned 1 Hz tick
  input wire ecrp_pkg::ecrp_req_t req_in, // Register access request
  input wire logic [7:0] nv_protect_enable_in, // Stored enable byte
  input wire logic [31:0] nv_key_reference_in, // Stored key reference
  output logic [7:0] rdata_out, // Read data, valid after read
  output logic unlocked_out, // Writes permitted as of the previous cycle, low at reset
  output logic [31:0] epoch_out // Epoch count
);
  typedef struct packed {
    logic [31:0] epoch;
    logic [7:0] scratch_a;
    logic [7:0] scratch_b;
    logic [31:0] key;
    logic [7:0] rdata;
    logic refreshed;
    logic [31:0] refresh_count;
    logic unlocked;
  } ecrp_state_t;

  ecrp_state_t state_reg;
  ecrp_state_t state_next;
  logic protect_on;
  logic write_ok;
  logic epoch_wr;
  logic epoch_sel;
  logic key_sel;
  logic tick_take;

  default clocking check_cb @(posedge clock_in);
  endclocking
  default disable iff (!rst_n_in);

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    state_next = state_reg;
    protect_on = (nv_protect_enable_in == ecrp_pkg::PROTECT_ON_VALUE); // R10
    write_ok = !protect_on || (state_reg.key == nv_key_reference_in); // R11 R16
    epoch_sel = (req_in.addr >= ecrp_pkg::EPOCH_BYTE0_ADDR) &&
      (req_in.addr <= ecrp_pkg::EPOCH_BYTE3_ADDR);
    key_sel = (req_in.addr >= ecrp_pkg::KEY_BYTE0_ADDR) &&
      (req_in.addr <= ecrp_pkg::KEY_BYTE3_ADDR);
    epoch_wr = req_in.wr && write_ok && epoch_sel;
    // A tick that meets an epoch write is dropped so the written bytes stay.
    tick_take = tick_in && !(req_in.wr && epoch_sel); // R4
    state_next.unlocked = write_ok;
    if (tick_take) begin // R4
      state_next.epoch = state_reg.epoch + 32'h0000_0001; // R1 R2 R3
    end
    if (req_in.wr) begin
      unique case (req_in.addr)
        ecrp_pkg::EPOCH_BYTE0_ADDR: if (write_ok) begin // R6 R7
          state_next.epoch[7:0] = req_in.wdata; // R5
        end
        ecrp_pkg::EPOCH_BYTE1_ADDR: if (write_ok) begin
          state_next.epoch[15:8] = req_in.wdata; // R5
        end
        ecrp_pkg::EPOCH_BYTE2_ADDR: if (write_ok) begin
          state_next.epoch[23:16] = req_in.wdata; // R5
        end
        ecrp_pkg::EPOCH_BYTE3_ADDR: if (write_ok) begin
          state_next.epoch[31:24] = req_in.wdata; // R5
        end
        ecrp_pkg::SCRATCH_A_ADDR: if (write_ok) begin
          state_next.scratch_a = req_in.wdata; // R8 R7
        end
        ecrp_pkg::SCRATCH_B_ADDR: if (write_ok) begin
          state_next.scratch_b = req_in.wdata; // R8 R7
        end
        ecrp_pkg::KEY_BYTE0_ADDR: state_next.key[7:0] = req_in.wdata; // R13
        ecrp_pkg::KEY_BYTE1_ADDR: state_next.key[15:8] = req_in.wdata; // R15
        ecrp_pkg::KEY_BYTE2_ADDR: state_next.key[23:16] = req_in.wdata; // R15
        ecrp_pkg::KEY_BYTE3_ADDR: state_next.key[31:24] = req_in.wdata; // R15
        default: begin
        end
      endcase
    end
    if (req_in.rd) begin
      unique case (req_in.addr)
        ecrp_pkg::EPOCH_BYTE0_ADDR: state_next.rdata = state_reg.epoch[7:0];
        ecrp_pkg::EPOCH_BYTE1_ADDR: state_next.rdata = state_reg.epoch[15:8];
        ecrp_pkg::EPOCH_BYTE2_ADDR: state_next.rdata = state_reg.epoch[23:16];
        ecrp_pkg::EPOCH_BYTE3_ADDR: state_next.rdata = state_reg.epoch[31:24];
        ecrp_pkg::SCRATCH_A_ADDR: state_next.rdata = state_reg.scratch_a;
        ecrp_pkg::SCRATCH_B_ADDR: state_next.rdata = state_reg.scratch_b;
        default: state_next.rdata = ecrp_pkg::BYTE_RESET; // R14
      endcase
    end
    // The key entry clears once, when the first refresh period ends.
    if (!state_reg.refreshed) begin
      if (state_reg.refresh_count >= 32'(REFRESH_CYCLES - 1)) begin
        state_next.refreshed = 1'b1;
        state_next.key = 32'h0000_0000; // R9
      end else begin
        state_next.refresh_count = state_reg.refresh_count + 32'h0000_0001;
      end
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_reg <= '0; // R17
    end else begin
      state_reg <= state_next;
    end
  end

  assign rdata_out = state_reg.rdata;
  assign unlocked_out = state_reg.unlocked;
  assign epoch_out = state_reg.epoch;

  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence tick_free_s;
    tick_in && !(req_in.wr && epoch_sel);
  endsequence

  sequence epoch_write_s;
    req_in.wr && epoch_sel;
  endsequence

  sequence open_write_s;
    req_in.wr && write_ok;
  endsequence

  sequence locked_write_s;
    req_in.wr && !write_ok;
  endsequence

  sequence key_write_s;
    req_in.wr && state_reg.refreshed;
  endsequence

  sequence key_read_s;
    req_in.rd && key_sel;
  endsequence

  sequence refresh_end_s;
    !state_reg.refreshed &&
    (state_reg.refresh_count >= 32'(REFRESH_CYCLES - 1));
  endsequence

  sequence protect_set_s;
    nv_protect_enable_in == ecrp_pkg::PROTECT_ON_VALUE;
  endsequence

  sequence key_match_s;
    state_reg.key == nv_key_reference_in;
  endsequence

  // ****************************************************************
  // Counter checks
  // ****************************************************************
  tick_advance_a: assert property ( // R3
    tick_free_s |=> epoch_out == $past(epoch_out) + 32'h0000_0001)
    else $error("epoch did not advance on tick");

  wrap_zero_a: assert property ( // R2
    tick_free_s ##0 (epoch_out == 32'hFFFF_FFFF)
    |=> epoch_out == ecrp_pkg::EPOCH_RESET)
    else $error("epoch did not wrap");

  idle_hold_a: assert property ( // R1
    !tick_in && !req_in.wr |=> $stable(epoch_out))
    else $error("epoch moved without tick or write");

  tick_drop_a: assert property ( // R4
    epoch_write_s ##0 !write_ok |=> $stable(epoch_out))
    else $error("tick not held off during epoch write");

  // ****************************************************************
  // Epoch byte write checks
  // ****************************************************************
  byte0_write_a: assert property ( // R4
    epoch_wr ##0 (req_in.addr == ecrp_pkg::EPOCH_BYTE0_ADDR)
    |=> epoch_out[7:0] == $past(req_in.wdata) &&
      epoch_out[31:8] == $past(epoch_out[31:8]))
    else $error("epoch byte 0 write not coherent");

  byte1_write_a: assert property ( // R5
    epoch_wr ##0 (req_in.addr == ecrp_pkg::EPOCH_BYTE1_ADDR)
    |=> epoch_out[15:8] == $past(req_in.wdata) &&
      epoch_out[7:0] == $past(epoch_out[7:0]))
    else $error("epoch byte 1 write not coherent");

  byte2_write_a: assert property ( // R5
    epoch_wr ##0 (req_in.addr == ecrp_pkg::EPOCH_BYTE2_ADDR)
    |=> epoch_out[23:16] == $past(req_in.wdata) &&
      epoch_out[15:0] == $past(epoch_out[15:0]))
    else $error("epoch byte 2 write not coherent");

  byte3_write_a: assert property ( // R6
    epoch_wr ##0 (req_in.addr == ecrp_pkg::EPOCH_BYTE3_ADDR)
    |=> epoch_out[31:24] == $past(req_in.wdata) &&
      epoch_out[23:0] == $past(epoch_out[23:0]))
    else $error("epoch byte 3 write not coherent");

  // ****************************************************************
  // Read checks
  // ****************************************************************
  byte0_read_a: assert property ( // R5
    req_in.rd && req_in.addr == ecrp_pkg::EPOCH_BYTE0_ADDR
    |=> rdata_out == $past(epoch_out[7:0]))
    else $error("epoch byte 0 read wrong");

  byte1_read_a: assert property ( // R5
    req_in.rd && req_in.addr == ecrp_pkg::EPOCH_BYTE1_ADDR
    |=> rdata_out == $past(epoch_out[15:8]))
    else $error("epoch byte 1 read wrong");

  byte2_read_a: assert property ( // R6
    req_in.rd && req_in.addr == ecrp_pkg::EPOCH_BYTE2_ADDR
    |=> rdata_out == $past(epoch_out[23:16]))
    else $error("epoch byte 2 read wrong");

  byte3_read_a: assert property ( // R6
    req_in.rd && req_in.addr == ecrp_pkg::EPOCH_BYTE3_ADDR
    |=> rdata_out == $past(epoch_out[31:24]))
    else $error("epoch byte 3 read wrong");

  read_hold_a: assert property ( // R7
    !req_in.rd |=> $stable(rdata_out))
    else $error("read data changed without read");

  // ****************************************************************
  // Scratch byte checks
  // ****************************************************************
  scratch_a_store_a: assert property ( // R8
    open_write_s ##0 (req_in.addr == ecrp_pkg::SCRATCH_A_ADDR)
    |=> state_reg.scratch_a == $past(req_in.wdata))
    else $error("scratch byte a not stored");

  scratch_b_store_a: assert property ( // R8
    open_write_s ##0 (req_in.addr == ecrp_pkg::SCRATCH_B_ADDR)
    |=> state_reg.scratch_b == $past(req_in.wdata))
    else $error("scratch byte b not stored");

  scratch_a_read_a: assert property ( // R7
    req_in.rd && req_in.addr == ecrp_pkg::SCRATCH_A_ADDR
    |=> rdata_out == $past(state_reg.scratch_a))
    else $error("scratch byte a read wrong");

  scratch_b_read_a: assert property ( // R7
    req_in.rd && req_in.addr == ecrp_pkg::SCRATCH_B_ADDR
    |=> rdata_out == $past(state_reg.scratch_b))
    else $error("scratch byte b read wrong");

  scratch_idle_a: assert property ( // R8
    !req_in.wr
    |=> $stable(state_reg.scratch_a) && $stable(state_reg.scratch_b))
    else $error("scratch byte changed without write");

  // ****************************************************************
  // Protection checks
  // ****************************************************************
  locked_block_a: assert property ( // R7
    locked_write_s
    |=> $stable(state_reg.scratch_a) && $stable(state_reg.scratch_b))
    else $error("locked write changed scratch byte");

  locked_epoch_a: assert property ( // R7
    locked_write_s ##0 !tick_in |=> $stable(epoch_out))
    else $error("locked write changed epoch");

  unlock_match_a: assert property ( // R11
    protect_set_s ##0 (state_reg.key != nv_key_reference_in)
    |=> !unlocked_out)
    else $error("unlocked without key");

  key_unlock_a: assert property ( // R11
    protect_set_s ##0 key_match_s |=> unlocked_out)
    else $error("matching key did not unlock");

  open_mode_a: assert property ( // R10
    nv_protect_enable_in != ecrp_pkg::PROTECT_ON_VALUE |=> unlocked_out)
    else $error("locked without protection");

  open_write_a: assert property ( // R16
    req_in.wr && !protect_on && req_in.addr == ecrp_pkg::SCRATCH_B_ADDR
    |=> state_reg.scratch_b == $past(req_in.wdata))
    else $error("open write refused");

  // ****************************************************************
  // Key entry checks
  // ****************************************************************
  key_read_zero_a: assert property ( // R14
    key_read_s |=> rdata_out == ecrp_pkg::BYTE_RESET)
    else $error("key byte read not zero");

  key_byte0_a: assert property ( // R13
    key_write_s ##0 (req_in.addr == ecrp_pkg::KEY_BYTE0_ADDR)
    |=> state_reg.key[7:0] == $past(req_in.wdata))
    else $error("key byte 0 not stored");

  key_byte1_a: assert property ( // R15
    key_write_s ##0 (req_in.addr == ecrp_pkg::KEY_BYTE1_ADDR)
    |=> state_reg.key[15:8] == $past(req_in.wdata))
    else $error("key byte 1 not stored");

  key_byte2_a: assert property ( // R15
    key_write_s ##0 (req_in.addr == ecrp_pkg::KEY_BYTE2_ADDR)
    |=> state_reg.key[23:16] == $past(req_in.wdata))
    else $error("key byte 2 not stored");

  key_byte3_a: assert property ( // R15
    key_write_s ##0 (req_in.addr == ecrp_pkg::KEY_BYTE3_ADDR)
    |=> state_reg.key[31:24] == $past(req_in.wdata))
    else $error("key byte 3 not stored");

  key_clear_a: assert property ( // R9
    refresh_end_s |=> state_reg.key == 32'h0000_0000)
    else $error("key entry not cleared after refresh");

  refresh_once_a: assert property ( // R9
    state_reg.refreshed |=> state_reg.refreshed)
    else $error("refresh flag fell");
endmodule // ecrp_regs
`default_nettype wire

// file: pkg/ecrp_pkg.sv
// Package of constants and carrier types for the epoch counter register bank.
`default_nettype none
package ecrp_pkg;
  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [7:0] EPOCH_BYTE0_ADDR = 8'h1B;
  localparam logic [7:0] EPOCH_BYTE1_ADDR = 8'h1C;
  localparam logic [7:0] EPOCH_BYTE2_ADDR = 8'h1D;
  localparam logic [7:0] EPOCH_BYTE3_ADDR = 8'h1E;
  localparam logic [7:0] SCRATCH_A_ADDR = 8'h1F;
  localparam logic [7:0] SCRATCH_B_ADDR = 8'h20;
  localparam logic [7:0] KEY_BYTE0_ADDR = 8'h21;
  localparam logic [7:0] KEY_BYTE1_ADDR = 8'h22;
  localparam logic [7:0] KEY_BYTE2_ADDR = 8'h23;
  localparam logic [7:0] KEY_BYTE3_ADDR = 8'h24;
  // ****************************************************************
  // Values and timing
  // ****************************************************************
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [7:0] PROTECT_ON_VALUE = 8'hFF;
  localparam logic [31:0] EPOCH_RESET = 32'h0000_0000;
  localparam int CLOCK_HZ = 50_000_000;
  localparam int REFRESH_MS = 66;
  localparam int REFRESH_CYCLES = REFRESH_MS * (CLOCK_HZ / 1000);
  // ****************************************************************
  // Carrier types
  // ****************************************************************
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ecrp_req_t;
endpackage
`default_nettype wire

// file: testbench/ecrp_host.sv
// Host controller model that issues register accesses to the bank.
`default_nettype none
module ecrp_host (
  input wire logic clock_in, // Bank clock
  output var ecrp_pkg::ecrp_req_t req_out // Access request
);
  timeunit 1ns;
  timeprecision 1ps;
  initial req_out = '0;
  // Called at a falling edge; holds the request over one rising edge.
  // Released address and data are inverted so stale values never match.
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    req_out = '{wr: w, rd: !w, addr: a, wdata: d};
    @(negedge clock_in);
    req_out = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    @(negedge clock_in);
  endtask
endmodule // ecrp_host
`default_nettype wire

// file: testbench/ecrp_regs_tb.sv
// Self-checking bench for the epoch counter register bank.
`default_nettype none
module ecrp_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic tick_in = 1'b0;
  logic [7:0] nv_en = 8'hFF;
  logic [31:0] nv_key = 32'h0;
  ecrp_pkg::ecrp_req_t req;
  logic [7:0] rdata;
  logic unlocked;
  logic [31:0] epoch;
  int failures = 0;
  int comparisons = 0;
  initial forever #10 clock_in = ~clock_in;
  ecrp_host host (.clock_in(clock_in), .req_out(req));
  ecrp_regs #(.REFRESH_CYCLES(10)) dut (.clock_in(clock_in),
    .rst_n_in(rst_n_in), .tick_in(tick_in), .req_in(req),
    .nv_protect_enable_in(nv_en), .nv_key_reference_in(nv_key),
    .rdata_out(rdata), .unlocked_out(unlocked), .epoch_out(epoch));
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.acc(1'b1, a, d);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    host.acc(1'b0, a, 8'h00);
    chk("read data", {24'h0, exp}, {24'h0, rdata});
  endtask
  task automatic wr_epoch(input logic [31:0] v);
    for (int i = 0; i < 4; i++) begin
      wr(8'(ecrp_pkg::EPOCH_BYTE0_ADDR + i), v[8*i +: 8]);
    end
  endtask
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic test_reset;
    rd_chk(ecrp_pkg::EPOCH_BYTE0_ADDR, 8'h00);
    rd_chk(ecrp_pkg::SCRATCH_A_ADDR, 8'h00);
    wr(ecrp_pkg::KEY_BYTE0_ADDR, 8'h3C);
    chk("unlocked", 32'h0, {31'h0, unlocked});
    repeat (12) @(negedge clock_in);
    chk("unlocked", 32'h1, {31'h0, unlocked});
    $display("test_reset done");
  endtask
  task automatic test_open;
    nv_en = 8'h00;
    @(negedge clock_in);
    wr_epoch(32'h1234_5678);
    chk("epoch", 32'h1234_5678, epoch);
    rd_chk(ecrp_pkg::EPOCH_BYTE3_ADDR, 8'h12);
    wr(ecrp_pkg::SCRATCH_B_ADDR, 8'hA5);
    rd_chk(ecrp_pkg::SCRATCH_B_ADDR, 8'hA5);
    wr(ecrp_pkg::KEY_BYTE0_ADDR, 8'h3C);
    rd_chk(ecrp_pkg::KEY_BYTE0_ADDR, 8'h00);
    $display("test_open done");
  endtask
  task automatic test_tick;
    wr_epoch(32'hFFFF_FFFF);
    tick_in = 1'b1;
    @(negedge clock_in);
    tick_in = 1'b0;
    chk("epoch", 32'h0, epoch);
    fork
      wr(ecrp_pkg::EPOCH_BYTE1_ADDR, 8'h77);
      begin
        tick_in = 1'b1;
        @(negedge clock_in);
        tick_in = 1'b0;
      end
    join
    chk("epoch", 32'h0000_7700, epoch);
    $display("test_tick done");
  endtask
  task automatic test_protect;
    nv_key = 32'hA1B2_C3D4;
    nv_en = ecrp_pkg::PROTECT_ON_VALUE;
    @(negedge clock_in);
    wr(ecrp_pkg::SCRATCH_A_ADDR, 8'h11);
    rd_chk(ecrp_pkg::SCRATCH_A_ADDR, 8'h00);
    for (int i = 0; i < 4; i++) begin
      wr(8'(ecrp_pkg::KEY_BYTE0_ADDR + i), nv_key[8*i +: 8]);
    end
    @(negedge clock_in);
    chk("unlocked", 32'h1, {31'h0, unlocked});
    wr(ecrp_pkg::SCRATCH_A_ADDR, 8'h11);
    rd_chk(ecrp_pkg::SCRATCH_A_ADDR, 8'h11);
    $display("test_protect done");
  endtask
  task automatic finish_test;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(negedge clock_in);
    rst_n_in = 1'b1;
    @(negedge clock_in);
    test_reset;
    test_open;
    test_tick;
    test_protect;
    finish_test;
  end
  initial begin
    #200us;
    failures++;
    finish_test;
  end
endmodule // ecrp_regs_tb
`default_nettype wire
